// ==== src/ic_top.sv ====
`timescale 1ns/1ns
// Summary of operation
// - four byte registers at 24..26 counter data, 27 control word
// - sixteen-bit counts move as low and high byte through the data port
// - control word: select 7:6, access 5:4, mode 3:1, decimal bit 0
// - select 00/01/10 picks counter 0/1/2; 11 means read-back command
// - access 00 latch, 01 low only, 10 high only, 11 low then high
// - mode codes 000 and 001 give modes 0 and 1; other codes are stored but never count
// - decimal bit 0 counts binary 0..65535, 1 counts decimal 0..9999
// - read-back bits 3,2,1 pick counters 2,1,0; bit 0 ignored
// - read-back with bit 5 low latches count of each picked counter
// - read-back with bit 4 low latches status of each picked counter
// - latched status read gives output, null flag, and programmed settings
// - null flag reads 1 once the written count reached the counting element
// - mode 0: output low on programming, high at terminal count
// - mode 0: counting continues past terminal count without reload
// - mode 0: first byte of rewrite halts, second byte restarts count
// - mode 1: output high, low on count after gate rise, high at end
// - mode 1: new count during pulse only used at next trigger
// - mode 1: reading the count never disturbs the pulse
// - mode 1: every gate rise restarts the full count
// - counter latch holds count in 16-bit register for following reads
module ic_top
(
   // system
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   // register port
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output      logic [7:0]               reg_rdata,
   // counter pins
   input  wire logic [ic_pkg::IC_NUM_CNT-1:0] cnt_clk_in,
   input  wire logic [ic_pkg::IC_NUM_CNT-1:0] cnt_gate_in,
   output      logic [ic_pkg::IC_NUM_CNT-1:0] cnt_out
);
   import ic_pkg::*;

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic ic_is_data(input logic [7:0] a);
      return (a == IC_OFS_DATA0) || (a == IC_OFS_DATA1) || (a == IC_OFS_DATA2);
   endfunction : ic_is_data

   function automatic logic [1:0] ic_data_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - IC_OFS_DATA0;
      return d[1:0];
   endfunction : ic_data_idx

   logic       cw_wr;
   logic [1:0] cw_sel;
   logic [1:0] cw_acc;
   logic       cw_rb;
   logic       dat_wr_any;
   logic       dat_rd_any;
   logic [1:0] dat_idx;

   assign cw_wr      = reg_wr && (reg_addr == IC_OFS_CTRL);
   assign cw_sel     = reg_wdata[IC_CW_SEL_LSB +: 2];
   assign cw_acc     = reg_wdata[IC_CW_ACC_LSB +: 2];
   assign cw_rb      = cw_wr && (cw_sel == IC_SEL_READBACK);
   assign dat_wr_any = reg_wr && ic_is_data(reg_addr);
   assign dat_rd_any = reg_rd && ic_is_data(reg_addr);
   assign dat_idx    = ic_data_idx(reg_addr);

   logic [7:0] rd_byte [IC_NUM_CNT];

   // ****************************************
   // per-counter logic
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < IC_NUM_CNT; gi++)
      begin : g_cnt
         localparam logic [1:0] MY_SEL = 2'(gi);

         ic_ce_if ce_if ();

         ic_count_elem u_elem
         (
            .sys_clk (sys_clk),
            .rstn    (rstn),
            .ce      (ce_if.elem)
         );

         // ---- pin synchronisers, three stages each ----
         logic [2:0] clk_s_reg;
         logic [2:0] gate_s_reg;
         logic       clk_lvl_reg;
         logic       gate_lvl_reg;
         logic       tick;
         logic       gate_rise;

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               clk_s_reg  <= 3'h0;
               gate_s_reg <= 3'h0;
            end
            else
            begin
               clk_s_reg  <= {clk_s_reg[1:0], cnt_clk_in[gi]};
               gate_s_reg <= {gate_s_reg[1:0], cnt_gate_in[gi]};
            end
         end

         // a level only counts once stages two and three agree
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               clk_lvl_reg  <= 1'b0;
               gate_lvl_reg <= 1'b0;
            end
            else
            begin
               if (clk_s_reg[1] == clk_s_reg[2])
                  clk_lvl_reg <= clk_s_reg[2];
               if (gate_s_reg[1] == gate_s_reg[2])
                  gate_lvl_reg <= gate_s_reg[2];
            end
         end

         assign tick      = (clk_s_reg[1] == clk_s_reg[2]) && clk_s_reg[2] && !clk_lvl_reg;
         assign gate_rise = (gate_s_reg[1] == gate_s_reg[2]) && gate_s_reg[2]
                            && !gate_lvl_reg;

         // ---- bus events for this counter ----
         logic [5:0] cfg_reg;
         logic [1:0] acc;
         logic [2:0] mode;
         logic       cfg_hit;
         logic       latch_cmd;
         logic       stat_cmd;
         logic       dat_wr;
         logic       dat_rd;
         logic       wr_hi_reg;
         logic       wr_first;
         logic       wr_done;

         assign acc  = cfg_reg[IC_CFG_ACC_LSB +: 2];
         assign mode = cfg_reg[IC_CFG_MODE_LSB +: 3];

         assign cfg_hit   = cw_wr && (cw_sel == MY_SEL) && (cw_acc != IC_ACC_LATCH);
         assign latch_cmd = (cw_wr && (cw_sel == MY_SEL) && (cw_acc == IC_ACC_LATCH))
                            || (cw_rb && !reg_wdata[IC_RB_CNT_BIT]
                                && reg_wdata[IC_RB_PICK_LSB + gi]);
         assign stat_cmd  = cw_rb && !reg_wdata[IC_RB_STA_BIT]
                            && reg_wdata[IC_RB_PICK_LSB + gi];
         assign dat_wr    = dat_wr_any && (dat_idx == MY_SEL);
         assign dat_rd    = dat_rd_any && (dat_idx == MY_SEL);
         assign wr_first  = dat_wr && (acc == IC_ACC_BOTH) && !wr_hi_reg;
         assign wr_done   = dat_wr && ((acc != IC_ACC_BOTH) || wr_hi_reg);

         // all three mode bits are compared; only modes 0 and 1 are decoded
         logic is_m0;
         logic is_m1;
         assign is_m0 = (mode == IC_MODE0);
         assign is_m1 = (mode == IC_MODE1);

         // ---- programmed configuration ----
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               cfg_reg <= IC_CFG_RST;
            else if (cfg_hit)
               cfg_reg <= reg_wdata[5:0];
         end

         // ---- count register and write byte order ----
         logic [15:0] cr_reg;
         logic        have_cnt_reg;

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               cr_reg       <= IC_COUNT_RST;
               wr_hi_reg    <= 1'b0;
               have_cnt_reg <= 1'b0;
            end
            else if (cfg_hit)
            begin
               wr_hi_reg    <= 1'b0;
               have_cnt_reg <= 1'b0;
            end
            else if (dat_wr)
            begin
               case (acc)
                  IC_ACC_LO:   cr_reg <= {IC_BYTE_RST, reg_wdata};
                  IC_ACC_HI:   cr_reg <= {reg_wdata, IC_BYTE_RST};
                  IC_ACC_BOTH:
                  begin
                     if (wr_hi_reg)
                        cr_reg[15:8] <= reg_wdata;
                     else
                        cr_reg[7:0] <= reg_wdata;
                     wr_hi_reg <= !wr_hi_reg;
                  end
                  default:     cr_reg <= cr_reg;
               endcase
               if (wr_done)
                  have_cnt_reg <= 1'b1;
            end
         end

         // ---- run state ----
         ic_run_e run_reg;
         ic_run_e run_next;
         logic    do_load;
         logic    do_dec;

         always_comb
         begin
            run_next = run_reg;
            case (run_reg)
               IC_IDLE:
               begin
                  if (is_m0 && wr_done)
                     run_next = IC_ARMED;
                  else if (is_m1 && have_cnt_reg && gate_rise)
                     run_next = IC_ARMED;
               end
               IC_ARMED:
               begin
                  if (tick)
                     run_next = IC_RUN;
               end
               IC_RUN:
               begin
                  if (is_m0 && wr_first)
                     run_next = IC_HALT;
                  else if (is_m0 && wr_done)
                     run_next = IC_ARMED;
                  else if (is_m1 && gate_rise)
                     run_next = IC_ARMED;
               end
               IC_HALT:
               begin
                  if (wr_done)
                     run_next = IC_ARMED;
               end
               default: run_next = IC_IDLE;
            endcase
            if (cfg_hit)
               run_next = IC_IDLE;
         end

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               run_reg <= IC_IDLE;
            else
               run_reg <= run_next;
         end

         // mode 1 loads only at a trigger, so a later write waits for the next one
         assign do_load = (run_reg == IC_ARMED) && tick && !cfg_hit;
         assign do_dec  = (run_reg == IC_RUN) && tick && !cfg_hit
                          && !(is_m0 && wr_first);

         assign ce_if.load  = do_load;
         assign ce_if.value = cr_reg;
         assign ce_if.dec   = do_dec;
         assign ce_if.bcd   = cfg_reg[IC_CW_BCD_BIT];

         // ---- output pin ----
         logic out_reg;

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               out_reg <= 1'b1;
            else if (cfg_hit)
               out_reg <= (reg_wdata[IC_CW_MODE_LSB +: 3] != IC_MODE0);
            else if (is_m0 && wr_done)
               out_reg <= 1'b0;
            else if (is_m1 && do_load)
               out_reg <= 1'b0;
            else if (do_dec && (ce_if.count == IC_COUNT_ONE))
               out_reg <= 1'b1;
         end

         assign cnt_out[gi] = out_reg;

         // ---- null count flag ----
         // a load in the same cycle as a write wins; the load takes the old count and the write does not rearm
         logic null_reg;

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               null_reg <= 1'b0;
            else if (do_load)
               null_reg <= 1'b1;
            else if (cfg_hit || wr_done)
               null_reg <= 1'b0;
         end

         // ---- count latch ----
         logic [15:0] ol_reg;
         logic        ol_valid_reg;
         logic        rd_hi_reg;
         logic        st_valid_reg;
         logic [7:0]  st_reg;
         logic        rd_cnt;
         logic        rd_last;
         logic [15:0] rd_src;

         assign rd_cnt  = dat_rd && !st_valid_reg;
         assign rd_last = (acc != IC_ACC_BOTH) || rd_hi_reg;

         // a second latch before the first is read out is ignored
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               ol_reg       <= IC_COUNT_RST;
               ol_valid_reg <= 1'b0;
            end
            else if (cfg_hit)
               ol_valid_reg <= 1'b0;
            else if (latch_cmd && !ol_valid_reg)
            begin
               ol_reg       <= ce_if.count;
               ol_valid_reg <= 1'b1;
            end
            else if (rd_cnt && rd_last)
               ol_valid_reg <= 1'b0;
         end

         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
               rd_hi_reg <= 1'b0;
            else if (cfg_hit)
               rd_hi_reg <= 1'b0;
            else if (rd_cnt && (acc == IC_ACC_BOTH))
               rd_hi_reg <= !rd_hi_reg;
         end

         // ---- status latch ----
         always_ff @(posedge sys_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               st_reg       <= IC_BYTE_RST;
               st_valid_reg <= 1'b0;
            end
            else if (stat_cmd && !st_valid_reg)
            begin
               st_reg       <= {out_reg, null_reg, cfg_reg};
               st_valid_reg <= 1'b1;
            end
            else if (dat_rd && st_valid_reg)
               st_valid_reg <= 1'b0;
         end

         // live reads only sample the count, so the pulse runs on untouched
         assign rd_src = ol_valid_reg ? ol_reg : ce_if.count;

         always_comb
         begin
            if (st_valid_reg)
               rd_byte[gi] = st_reg;
            else if ((acc == IC_ACC_HI) || ((acc == IC_ACC_BOTH) && rd_hi_reg))
               rd_byte[gi] = rd_src[15:8];
            else
               rd_byte[gi] = rd_src[7:0];
         end
      end
   endgenerate

   // ****************************************
   // read data
   // ****************************************
   // control port and unmapped offsets read back as zero
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= IC_UNMAPPED_RD;
      else if (reg_rd)
      begin
         if (dat_rd_any)
            reg_rdata <= rd_byte[dat_idx];
         else
            reg_rdata <= IC_UNMAPPED_RD;
      end
   end

endmodule : ic_top

// ==== src/ic_pkg.sv ====
package ic_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int IC_NUM_CNT = 3;

   // ****************************************
   // register offsets from the i/o base
   // ****************************************
   localparam logic [7:0] IC_OFS_DATA0 = 8'h18;
   localparam logic [7:0] IC_OFS_DATA1 = 8'h19;
   localparam logic [7:0] IC_OFS_DATA2 = 8'h1a;
   localparam logic [7:0] IC_OFS_CTRL  = 8'h1b;

   // ****************************************
   // control word and read-back field positions
   // ****************************************
   localparam int IC_CW_SEL_LSB   = 6;
   localparam int IC_CW_ACC_LSB   = 4;
   localparam int IC_CW_MODE_LSB  = 1;
   localparam int IC_CW_BCD_BIT   = 0;
   localparam int IC_RB_CNT_BIT   = 5;
   localparam int IC_RB_STA_BIT   = 4;
   localparam int IC_RB_PICK_LSB  = 1;
   localparam int IC_CFG_ACC_LSB  = 4;
   localparam int IC_CFG_MODE_LSB = 1;

   // ****************************************
   // field encodings
   // ****************************************
   localparam logic [1:0] IC_SEL_READBACK = 2'h3;
   localparam logic [1:0] IC_ACC_LATCH    = 2'h0;
   localparam logic [1:0] IC_ACC_LO       = 2'h1;
   localparam logic [1:0] IC_ACC_HI       = 2'h2;
   localparam logic [1:0] IC_ACC_BOTH     = 2'h3;
   localparam logic [2:0] IC_MODE0        = 3'h0;
   localparam logic [2:0] IC_MODE1        = 3'h1;

   // ****************************************
   // reset values and constants
   // ****************************************
   localparam logic [5:0]  IC_CFG_RST     = 6'h00;
   localparam logic [15:0] IC_COUNT_RST   = 16'h0000;
   localparam logic [15:0] IC_COUNT_ONE   = 16'h0001;
   localparam logic [7:0]  IC_BYTE_RST    = 8'h00;
   localparam logic [7:0]  IC_UNMAPPED_RD = 8'h00;

   // ****************************************
   // counter run state
   // ****************************************
   typedef enum logic [1:0]
   {
      IC_IDLE  = 2'b00,
      IC_ARMED = 2'b01,
      IC_RUN   = 2'b10,
      IC_HALT  = 2'b11
   } ic_run_e;

endpackage : ic_pkg

// ==== src/ic_ce_if.sv ====
`timescale 1ns/1ns
interface ic_ce_if;
   logic        load;
   logic [15:0] value;
   logic        dec;
   logic        bcd;
   logic [15:0] count;

   modport ctl
   (
      output load,
      output value,
      output dec,
      output bcd,
      input  count
   );

   modport elem
   (
      input  load,
      input  value,
      input  dec,
      input  bcd,
      output count
   );
endinterface : ic_ce_if

// ==== src/ic_count_elem.sv ====
`timescale 1ns/1ns
module ic_count_elem
(
   // system
   input wire logic sys_clk,
   input wire logic rstn,
   // control side
   ic_ce_if.elem    ce
);
   import ic_pkg::*;

   // ****************************************
   // decimal decrement, digit by digit
   // ****************************************
   function automatic logic [15:0] ic_bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         if (borrow)
         begin
            if (r[4*k +: 4] == 4'h0)
               r[4*k +: 4] = 4'h9;
            else
            begin
               r[4*k +: 4] = r[4*k +: 4] - 4'h1;
               borrow      = 1'b0;
            end
         end
      end
      return r;
   endfunction : ic_bcd_dec

   // ****************************************
   // counting element
   // ****************************************
   // wraps 0000 -> 9999 in decimal and 0000 -> ffff in binary
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         ce.count <= IC_COUNT_RST;
      else if (ce.load)
         ce.count <= ce.value;
      else if (ce.dec)
         ce.count <= ce.bcd ? ic_bcd_dec(ce.count) : ce.count - IC_COUNT_ONE;
   end

endmodule : ic_count_elem

// ==== dv/ic_top_assertions.sv ====
`timescale 1ns/1ns
module ic_top_assertions
   import ic_pkg::*;
(
   // system
   input wire logic                           sys_clk,
   input wire logic                           rstn,
   // register port
   input wire logic [7:0]                     reg_addr,
   input wire logic [7:0]                     reg_wdata,
   input wire logic                           reg_wr,
   input wire logic                           reg_rd,
   input wire logic [7:0]                     reg_rdata,
   // counter pins
   input wire logic [ic_pkg::IC_NUM_CNT-1:0] cnt_clk_in,
   input wire logic [ic_pkg::IC_NUM_CNT-1:0] cnt_gate_in,
   input wire logic [ic_pkg::IC_NUM_CNT-1:0] cnt_out
);
   logic [3:0] age_reg;
   logic       m0_reg;
   logic       cw0;

   assign cw0 = reg_wr && reg_addr == IC_OFS_CTRL && reg_wdata[7:4] != 4'h0 && !reg_wdata[7];

   // cycles since a rising counter 0 clock pin; ticks lag it by the synchroniser
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         age_reg <= 4'hf;
      else if ($rose(cnt_clk_in[0]))
         age_reg <= 4'h0;
      else if (age_reg != 4'hf)
         age_reg <= age_reg + 4'h1;
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         m0_reg <= 1'b0;
      else if (cw0 && !reg_wdata[6])
         m0_reg <= reg_wdata[3:1] == IC_MODE0;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_ctrl_rd_zero: assert property (reg_rd && reg_addr == IC_OFS_CTRL
      |=> reg_rdata == 8'h00) else $error("control port read not zero");
   a_unmapped_zero: assert property (reg_rd
      && (reg_addr < IC_OFS_DATA0 || reg_addr > IC_OFS_CTRL)
      |=> reg_rdata == IC_UNMAPPED_RD) else $error("unmapped read not zero");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_mode0_low: assert property (cw0 && !reg_wdata[6] && reg_wdata[3:1] == IC_MODE0
      |=> !cnt_out[0]) else $error("mode 0 output not low after programming");
   a_mode1_high: assert property (cw0 && !reg_wdata[6] && reg_wdata[3:1] == IC_MODE1
      |=> cnt_out[0]) else $error("mode 1 output not high after programming");
   a_out_cause: assert property ($changed(cnt_out[0]) && !$past(reg_wr)
      |-> age_reg < 4'h8) else $error("output moved with no clock tick");
   a_stay_high: assert property (m0_reg && cnt_out[0] && !reg_wr |=> cnt_out[0])
      else $error("mode 0 output left high without a write");
   a_read_quiet: assert property (reg_rd && age_reg > 4'h7 |=> $stable(cnt_out[0]))
      else $error("read disturbed the output");
endmodule : ic_top_assertions

bind ic_top ic_top_assertions ic_top_assertions_i (.sys_clk, .rstn, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .cnt_clk_in, .cnt_gate_in, .cnt_out);

// ==== dv/ic_host.sv ====
`timescale 1ns/1ns
module ic_host
(
   // clock
   input  wire logic       sys_clk,
   // register port
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   output      logic       reg_wr,
   output      logic       reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // one strobe cycle per byte; callers send the bytes the access field asks for, after a control word except when rewriting a running count
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      #1;
      reg_addr  = a;
      reg_wdata = v;
      reg_wr    = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr    = 1'b0;
      // released bus carries garbage, not the last byte
      reg_wdata = ~v;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge sys_clk);
      #1;
      v        = reg_rdata;
      reg_rd   = 1'b0;
   endtask : rd
endmodule : ic_host

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   import ic_pkg::*;
   logic                  sys_clk     = 1'b0;
   logic                  rstn        = 1'b0;
   logic [7:0]            reg_addr;
   logic [7:0]            reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [7:0]            reg_rdata;
   logic [IC_NUM_CNT-1:0] cnt_clk_in  = '0;
   logic [IC_NUM_CNT-1:0] cnt_gate_in = '0;
   logic [IC_NUM_CNT-1:0] cnt_out;
   logic [7:0]            d;
   logic [31:0]           seed        = 32'ha315;
   int                    mismatches  = 0;
   int                    cmp_count   = 0;
   int                    mcnt[3];
   bit                    mrun[3];
   bit                    mbcd[3];
   int                    n;

   always #4 sys_clk = ~sys_clk;

   ic_top ic_top_i (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cnt_clk_in, .cnt_gate_in, .cnt_out);
   ic_host ic_host_i (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

   // ****************************************
   // model and helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   function automatic logic [15:0] enc(input int v, input bit b);
      return b ? {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)} : 16'(v);
   endfunction : enc

   task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask : chk

   // high and low phases each outlast the pin synchroniser
   task automatic pulse(input int i, input int k);
      repeat (k)
      begin
         @(posedge sys_clk);
         #1 cnt_clk_in[i] = 1'b1;
         repeat (4) @(posedge sys_clk);
         #1 cnt_clk_in[i] = 1'b0;
         repeat (3) @(posedge sys_clk);
         #1;
         if (mrun[i])
            mcnt[i] = mcnt[i] == 0 ? (mbcd[i] ? 9999 : 65535) : mcnt[i] - 1;
      end
   endtask : pulse

   task automatic gate(input int i);
      @(posedge sys_clk);
      #1 cnt_gate_in[i] = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1 cnt_gate_in[i] = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
   endtask : gate

   task automatic load(input int i, input int v);
      mrun[i] = 1'b0;
      pulse(i, 1);
      mcnt[i] = v;
      mrun[i] = 1'b1;
   endtask : load

   task automatic arm(input int i, input int v);
      logic [15:0] e;
      e = enc(v, mbcd[i]);
      ic_host_i.wr(IC_OFS_DATA0 + 8'(i), e[7:0]);
      ic_host_i.wr(IC_OFS_DATA0 + 8'(i), e[15:8]);
   endtask : arm

   // latch by cmd, let gap ticks pass, then read the bytes that acc names
   task automatic rdcnt(input int i, input logic [1:0] acc, input logic [7:0] cmd, input int gap);
      logic [15:0] e;
      logic [7:0]  lo;
      logic [7:0]  hi;
      e  = enc(mcnt[i], mbcd[i]);
      lo = e[7:0];
      hi = e[15:8];
      ic_host_i.wr(IC_OFS_CTRL, cmd);
      pulse(i, gap);
      if (acc[0])
         ic_host_i.rd(IC_OFS_DATA0 + 8'(i), lo);
      if (acc[1])
         ic_host_i.rd(IC_OFS_DATA0 + 8'(i), hi);
      chk("count", {hi, lo}, e);
   endtask : rdcnt

   task automatic sta(input int i, input logic [7:0] e);
      ic_host_i.wr(IC_OFS_CTRL, 8'he0 | (8'h02 << i));
      ic_host_i.rd(IC_OFS_DATA0 + 8'(i), d);
      chk("status", {8'h00, d}, {8'h00, e});
   endtask : sta

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test

   // ****************************************
   // sequence
   // ****************************************
   initial
   begin
      repeat (20) @(posedge sys_clk);
      #1 rstn = 1'b1;
      ic_host_i.rd(IC_OFS_CTRL, d);
      chk("ctrl read", {8'h00, d}, 16'h0000);
      ic_host_i.rd(8'h20, d);
      chk("unmapped read", {8'h00, d}, 16'h0000);
      $display("test map done");
      seed = xs(seed);
      n = 3 + int'(seed[2:0]);
      ic_host_i.wr(IC_OFS_CTRL, 8'h30);
      arm(0, n);
      sta(0, 8'h30);
      load(0, n);
      sta(0, 8'h70);
      pulse(0, n - 1);
      chk("out0", 16'(cnt_out[0]), 16'h0000);
      pulse(0, 1);
      chk("out0", 16'(cnt_out[0]), 16'h0001);
      pulse(0, 2);
      rdcnt(0, 2'h3, 8'h00, 2);
      $display("test mode 0 done");
      mbcd[1] = 1'b1;
      ic_host_i.wr(IC_OFS_CTRL, 8'h71);
      arm(1, 10);
      load(1, 10);
      pulse(1, 1);
      rdcnt(1, 2'h3, 8'hd4, 0);
      chk("out1", 16'(cnt_out[1]), 16'h0000);
      // one read-back latches status and count of counters 0 and 1 together
      ic_host_i.wr(IC_OFS_CTRL, 8'hc6);
      ic_host_i.rd(IC_OFS_DATA1, d);
      chk("status1", {8'h00, d}, 16'h0071);
      rdcnt(1, 2'h3, 8'hc0, 0);
      ic_host_i.rd(IC_OFS_DATA0, d);
      chk("status0", {8'h00, d}, 16'h00f0);
      rdcnt(0, 2'h3, 8'hc0, 0);
      $display("test decimal done");
      ic_host_i.wr(IC_OFS_CTRL, 8'hb0);
      arm(2, 4);
      load(2, 4);
      pulse(2, 2);
      ic_host_i.wr(IC_OFS_DATA2, 8'h08);
      mrun[2] = 1'b0;
      pulse(2, 3);
      chk("out2", 16'(cnt_out[2]), 16'h0000);
      ic_host_i.wr(IC_OFS_DATA2, 8'h00);
      load(2, 8);
      pulse(2, 1);
      rdcnt(2, 2'h3, 8'h80, 0);
      ic_host_i.wr(IC_OFS_CTRL, 8'h90);
      ic_host_i.wr(IC_OFS_DATA2, 8'h05);
      load(2, 5);
      pulse(2, 1);
      rdcnt(2, 2'h1, 8'h80, 0);
      ic_host_i.wr(IC_OFS_CTRL, 8'ha0);
      ic_host_i.wr(IC_OFS_DATA2, 8'h02);
      load(2, 512);
      rdcnt(2, 2'h2, 8'h80, 0);
      $display("test rewrite and access done");
      ic_host_i.wr(IC_OFS_CTRL, 8'h12);
      mrun[0] = 1'b0;
      ic_host_i.wr(IC_OFS_DATA0, 8'h03);
      pulse(0, 1);
      chk("out0", 16'(cnt_out[0]), 16'h0001);
      gate(0);
      load(0, 3);
      chk("out0", 16'(cnt_out[0]), 16'h0000);
      rdcnt(0, 2'h1, 8'h00, 1);
      ic_host_i.wr(IC_OFS_DATA0, 8'h05);
      pulse(0, 1);
      chk("out0", 16'(cnt_out[0]), 16'h0000);
      pulse(0, 1);
      chk("out0", 16'(cnt_out[0]), 16'h0001);
      gate(0);
      load(0, 5);
      pulse(0, 2);
      gate(0);
      load(0, 5);
      pulse(0, 4);
      chk("out0", 16'(cnt_out[0]), 16'h0000);
      pulse(0, 1);
      chk("out0", 16'(cnt_out[0]), 16'h0001);
      $display("test mode 1 done");
      for (int m = 0; m < 8; m++)
      begin
         ic_host_i.wr(IC_OFS_CTRL, {4'h7, 3'(m), 1'(m)});
         sta(1, {m != 0, 3'h3, 3'(m), 1'(m)});
      end
      $display("test mode codes done");
      end_of_test();
   end

   // whole sequence needs well under a thousand cycles; this allows ample margin
   initial
   begin
      #400000;
      mismatches++;
      end_of_test();
   end
endmodule : tb_top
